/* logic/scd_burst.v */
/*
  Burst tracker: counts the beats of one read or write burst.
  Assumes start pulses only while idle; a start at the last beat is ignored.
*/
`timescale 1ns/1ps
`include "scd_regs.vh"

module scd_burst #(
  parameter LEN_W = 4
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [LEN_W-1:0] len_in,
  output wire busy_out,
  output wire last_out
);

  reg [LEN_W-1:0] cnt_reg;
  reg [LEN_W-1:0] cnt_next;

  // Later commands never reload a running count
  always @*
  begin
    cnt_next = cnt_reg;
    if (cnt_reg != {LEN_W{1'b0}})
      cnt_next = cnt_reg - {{(LEN_W-1){1'b0}}, 1'b1}; // RL15
    else if (start_in)
      cnt_next = len_in;
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_reg <= {LEN_W{1'b0}};
    else
      cnt_reg <= cnt_next;
  end

  assign busy_out = (cnt_reg != {LEN_W{1'b0}});
  assign last_out = (cnt_reg == {{(LEN_W-1){1'b0}}, 1'b1});

endmodule // scd_burst

/* logic/scd_decode.v */
/*
  SDRAM command decoder with calibration pattern read mode.
  Assumes command inputs synchronous to clk_in and a controller that
  keeps its own sequencing obligations.
*/
// Functional notes
// RL1 - Controller writes third mode register with bank select 3.
// RL2 - Mode set to third mode register with A2 high enables pattern mode.
// RL3 - Controller precharges all banks before enabling pattern mode.
// RL4 - Reads in pattern mode return the pattern register, not the array.
// RL5 - Controller issues only reads in pattern mode until A2 cleared.
// RL6 - Asynchronous reset still works during pattern mode.
// RL7 - Commands decoded from sampled lines at rising clock edge.
// RL8 - Mode set: all lines low, clock enable high; bank picks register.
// RL9 - Write decode with auto-precharge and on-the-fly burst chop.
// RL10 - Read decode with auto-precharge and on-the-fly burst chop.
// RL11 - No-operation registers nothing and leaves bursts running.
// RL12 - Deselect ignores all other lines, same as no-operation.
// RL13 - Self-refresh exit on clock enable rising, with deselect or nop.
// RL14 - Controller keeps reset high during normal commands.
// RL15 - Bursts run to completion, never cut short by commands.
// RL16 - No refresh performed while in power-down.
// RL17 - Termination input ignored and unavailable in self-refresh.
// RL18 - Refresh or self-refresh entry by clock enable history.
// RL19 - Activate, or precharge single or all by A10.
// RL20 - Impedance calibration long or short by A10.
// RL21 - Controller uses nop or deselect on power-down edges.
// RL22 - Controller enters self-refresh only with banks idle.
`timescale 1ns/1ps
`include "scd_regs.vh"

module scd_decode #(
  parameter ADDR_W = 14,
  parameter BANK_W = 3,
  parameter PAT_W = 8,
  parameter [7:0] PAT_VALUE = 8'h55
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire cke_in,
  input wire cs_n_in,
  input wire ras_n_in,
  input wire cas_n_in,
  input wire we_n_in,
  input wire [BANK_W-1:0] bank_select_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire odt_in,
  output reg cmd_valid_out,
  output reg [3:0] cmd_code_out,
  output reg [BANK_W-1:0] cmd_bank_out,
  output reg [ADDR_W-1:0] cmd_addr_out,
  output reg auto_precharge_select_out,
  output reg burst_chop_select_out,
  output reg pattern_mode_out,
  output reg pattern_read_out,
  output reg array_read_out,
  output reg [PAT_W-1:0] pattern_data_out,
  output reg burst_busy_out,
  output reg refresh_out,
  output reg [1:0] power_state_out,
  output reg odt_active_out
);

  // ---------------------------------------------------------------
  // Command capture
  // ---------------------------------------------------------------
  reg cke_prev_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg pat_en_reg;
  reg [1:0] bl_mode_reg;
  wire [3:0] lines = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire cmd_nop = cs_n_in || (lines == `SCD_CMD_NOP); // RL11 RL12
  wire cke_hh = cke_prev_reg && cke_in;
  wire cke_hl = cke_prev_reg && !cke_in;
  wire cke_lh = !cke_prev_reg && cke_in;
  wire burst_busy;
  wire burst_last;
  reg [3:0] op;
  reg burst_start;
  reg [3:0] burst_len;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always @*
  begin
    op = `SCD_OP_NONE;
    if (state_reg == `SCD_ST_SREF)
    begin
      if (cke_lh && cmd_nop)
        op = `SCD_OP_SREF_OUT; // RL13
    end
    else if (state_reg == `SCD_ST_PDOWN)
    begin
      if (cke_lh && cmd_nop)
        op = `SCD_OP_PDOWN_OUT;
    end
    else if (cke_hl)
    begin
      if (!cs_n_in && lines == `SCD_CMD_REF)
        op = `SCD_OP_SREF_IN; // RL18
      else if (cmd_nop)
        op = `SCD_OP_PDOWN_IN;
    end
    else if (cke_hh && !cs_n_in) // RL7
    begin
      case (lines)
        `SCD_CMD_MRS: op = `SCD_OP_MRS; // RL8
        `SCD_CMD_REF: op = `SCD_OP_REF; // RL18
        `SCD_CMD_PRE: op = addr_in[`SCD_AP_BIT] ? `SCD_OP_PREA : `SCD_OP_PRE; // RL19
        `SCD_CMD_ACT: op = `SCD_OP_ACT; // RL19
        `SCD_CMD_WR: op = `SCD_OP_WR; // RL9
        `SCD_CMD_RD: op = `SCD_OP_RD; // RL10
        `SCD_CMD_ZQ: op = addr_in[`SCD_AP_BIT] ? `SCD_OP_ZQL : `SCD_OP_ZQS; // RL20
        default: op = `SCD_OP_NONE; // RL11
      endcase
    end
  end

  // Burst length: fixed from mode register 0, or A12 when on the fly
  always @*
  begin
    burst_start = (op == `SCD_OP_WR || op == `SCD_OP_RD) && !burst_busy;
    case (bl_mode_reg)
      `SCD_BL_FIXED4: burst_len = `SCD_BURST_4;
      `SCD_BL_OTF: burst_len = addr_in[`SCD_BC_BIT] ? `SCD_BURST_8 : `SCD_BURST_4; // RL9 RL10
      default: burst_len = `SCD_BURST_8;
    endcase
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `SCD_ST_ACTIVE:
      begin
        if (op == `SCD_OP_SREF_IN)
          state_next = `SCD_ST_SREF;
        else if (op == `SCD_OP_PDOWN_IN)
          state_next = `SCD_ST_PDOWN;
      end
      `SCD_ST_PDOWN:
      begin
        if (op == `SCD_OP_PDOWN_OUT)
          state_next = `SCD_ST_ACTIVE;
      end
      `SCD_ST_SREF:
      begin
        if (op == `SCD_OP_SREF_OUT)
          state_next = `SCD_ST_ACTIVE; // RL13
      end
      default: state_next = `SCD_ST_ACTIVE;
    endcase
  end

  scd_burst #(
    .LEN_W(4)
  ) u_burst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(burst_start),
    .len_in(burst_len),
    .busy_out(burst_busy),
    .last_out(burst_last)
  );

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  // Reset acts at any time, pattern mode included
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in) // RL6
    begin
      cke_prev_reg <= 1'b0;
      state_reg <= `SCD_ST_ACTIVE;
      pat_en_reg <= 1'b0;
      bl_mode_reg <= `SCD_BL_FIXED8;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= `SCD_OP_NONE;
      cmd_bank_out <= {BANK_W{1'b0}};
      cmd_addr_out <= {ADDR_W{1'b0}};
      auto_precharge_select_out <= 1'b0;
      burst_chop_select_out <= 1'b0;
      pattern_mode_out <= 1'b0;
      pattern_read_out <= 1'b0;
      array_read_out <= 1'b0;
      pattern_data_out <= {PAT_W{1'b0}};
      burst_busy_out <= 1'b0;
      refresh_out <= 1'b0;
      power_state_out <= `SCD_ST_ACTIVE;
      odt_active_out <= 1'b0;
    end
    else
    begin
      cke_prev_reg <= cke_in;
      state_reg <= state_next;
      cmd_valid_out <= (op != `SCD_OP_NONE);
      cmd_code_out <= op;
      if (op != `SCD_OP_NONE) // RL11
      begin
        cmd_bank_out <= bank_select_in;
        cmd_addr_out <= addr_in;
        auto_precharge_select_out <= addr_in[`SCD_AP_BIT]; // RL9 RL10
        burst_chop_select_out <= addr_in[`SCD_BC_BIT];
      end
      if (op == `SCD_OP_MRS && bank_select_in == `SCD_MODE3_SEL)
        pat_en_reg <= addr_in[`SCD_PAT_EN_BIT]; // RL2
      if (op == `SCD_OP_MRS && bank_select_in == `SCD_MR0_SEL)
        bl_mode_reg <= addr_in[`SCD_MR0_BL_HI:`SCD_MR0_BL_LO]; // RL15
      pattern_mode_out <= (op == `SCD_OP_MRS && bank_select_in == `SCD_MODE3_SEL) ?
        addr_in[`SCD_PAT_EN_BIT] : pat_en_reg;
      pattern_read_out <= (op == `SCD_OP_RD) && pat_en_reg; // RL4
      array_read_out <= (op == `SCD_OP_RD) && !pat_en_reg; // RL4
      if (op == `SCD_OP_RD && pat_en_reg)
        pattern_data_out <= PAT_VALUE[PAT_W-1:0]; // RL4
      burst_busy_out <= burst_start || (burst_busy && !burst_last); // RL15
      // Power-down never refreshes on its own
      refresh_out <= (op == `SCD_OP_REF) && (state_reg == `SCD_ST_ACTIVE); // RL16
      power_state_out <= state_next;
      odt_active_out <= odt_in && (state_next != `SCD_ST_SREF); // RL17
    end
  end

endmodule // scd_decode

/* logic/scd_regs.vh */
/*
  Constants for the command decoder: command codes, mode register
  selectors, address bit positions, state codes and burst lengths.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// -----------------------------------------------------------------
// Command codes on {cs_n, ras_n, cas_n, we_n}
// -----------------------------------------------------------------
`define SCD_CMD_MRS 4'h0
`define SCD_CMD_REF 4'h1
`define SCD_CMD_PRE 4'h2
`define SCD_CMD_ACT 4'h3
`define SCD_CMD_WR 4'h4
`define SCD_CMD_RD 4'h5
`define SCD_CMD_ZQ 4'h6
`define SCD_CMD_NOP 4'h7

// -----------------------------------------------------------------
// Decoded command codes on cmd_code_out
// -----------------------------------------------------------------
`define SCD_OP_NONE 4'h0
`define SCD_OP_MRS 4'h1
`define SCD_OP_REF 4'h2
`define SCD_OP_SREF_IN 4'h3
`define SCD_OP_SREF_OUT 4'h4
`define SCD_OP_PRE 4'h5
`define SCD_OP_PREA 4'h6
`define SCD_OP_ACT 4'h7
`define SCD_OP_WR 4'h8
`define SCD_OP_RD 4'h9
`define SCD_OP_ZQL 4'hA
`define SCD_OP_ZQS 4'hB
`define SCD_OP_PDOWN_IN 4'hC
`define SCD_OP_PDOWN_OUT 4'hD

// -----------------------------------------------------------------
// Mode register selectors and address bit positions
// -----------------------------------------------------------------
`define SCD_MODE3_SEL 3'h3
`define SCD_MR0_SEL 3'h0
`define SCD_PAT_EN_BIT 2
`define SCD_AP_BIT 10
`define SCD_BC_BIT 12
`define SCD_MR0_BL_LO 0
`define SCD_MR0_BL_HI 1

// -----------------------------------------------------------------
// Power states, burst lengths in clock beats and burst length modes
// -----------------------------------------------------------------
`define SCD_ST_ACTIVE 2'h0
`define SCD_ST_PDOWN 2'h1
`define SCD_ST_SREF 2'h2
`define SCD_BURST_8 4'h4
`define SCD_BURST_4 4'h2
`define SCD_BL_FIXED8 2'h0
`define SCD_BL_OTF 2'h1
`define SCD_BL_FIXED4 2'h2

`endif

/* verification/scd_ctrl.sv */
/* Controller model: drives the command lines, one command per call.
   Assumes a single calling process. */
`timescale 1ns/1ps
`include "scd_regs.vh"
module scd_ctrl (
  input wire clk_in,
  output reg cke_out,
  output reg [3:0] cmd_out,
  output reg [2:0] ba_out,
  output reg [13:0] addr_out
);
  initial
  begin
    cke_out = 1'b0;
    cmd_out = `SCD_CMD_NOP;
    ba_out = 3'h0;
    addr_out = 14'h0000;
  end
  // Bank and address invert after use and command returns to nop, so stale values never look valid
  task issue(input c, input [3:0] k, input [2:0] b, input [13:0] a);
    begin
      @(posedge clk_in);
      cke_out <= c;
      cmd_out <= k;
      ba_out <= b;
      addr_out <= a;
      @(posedge clk_in);
      cmd_out <= `SCD_CMD_NOP;
      ba_out <= ~b;
      addr_out <= ~a;
    end
  endtask
endmodule // scd_ctrl

/* verification/scd_decode_properties.sv */
/* Checker for the command decoder: timing of decoded outputs.
   Assumes binding to scd_decode and its port names. */
`timescale 1ns/1ps
`include "scd_regs.vh"
module scd_chk #(
  parameter [7:0] PAT_VALUE = 8'h55
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire cke_in,
  input wire cs_n_in,
  input wire ras_n_in,
  input wire cas_n_in,
  input wire we_n_in,
  input wire [2:0] bank_select_in,
  input wire [13:0] addr_in,
  input wire cmd_valid_out,
  input wire [3:0] cmd_code_out,
  input wire [2:0] cmd_bank_out,
  input wire [13:0] cmd_addr_out,
  input wire auto_precharge_select_out,
  input wire burst_chop_select_out,
  input wire pattern_mode_out,
  input wire pattern_read_out,
  input wire array_read_out,
  input wire [7:0] pattern_data_out,
  input wire burst_busy_out,
  input wire refresh_out,
  input wire [1:0] power_state_out,
  input wire odt_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  // Guard on reset history: the decoder forgets cke at reset
  sequence s_hh;
    cke_in && $past(cke_in) && $past(rst_n_in);
  endsequence
  AST_DESEL: assert property (s_hh ##0 cs_n_in |=> !cmd_valid_out)
    else $error("deselect decoded");
  AST_NOP: assert property (s_hh ##0 cmd == `SCD_CMD_NOP |=> !cmd_valid_out)
    else $error("nop decoded");
  AST_MRS: assert property (s_hh ##0 cmd == `SCD_CMD_MRS |=>
    cmd_code_out == `SCD_OP_MRS && cmd_bank_out == $past(bank_select_in) &&
    cmd_addr_out == $past(addr_in))
    else $error("mode set wrong");
  AST_REFRESH: assert property (s_hh ##0 cmd == `SCD_CMD_REF |=> refresh_out &&
    cmd_code_out == `SCD_OP_REF) else $error("refresh not reported");
  AST_RD: assert property (s_hh ##0 cmd == `SCD_CMD_RD |=> cmd_code_out == `SCD_OP_RD &&
    auto_precharge_select_out == $past(addr_in[10]) && burst_chop_select_out == $past(addr_in[12]))
    else $error("read wrong");
  AST_WR: assert property (s_hh ##0 cmd == `SCD_CMD_WR |=> cmd_code_out == `SCD_OP_WR &&
    auto_precharge_select_out == $past(addr_in[10]) && burst_chop_select_out == $past(addr_in[12]))
    else $error("write wrong");
  AST_PAT: assert property (s_hh ##0 cmd == `SCD_CMD_MRS && bank_select_in == 3'h3 |=>
    pattern_mode_out == $past(addr_in[2])) else $error("pattern mode wrong");
  AST_PATRD: assert property (s_hh ##0 cmd == `SCD_CMD_RD && pattern_mode_out |=>
    pattern_read_out && !array_read_out && pattern_data_out == PAT_VALUE)
    else $error("pattern read wrong");
  AST_SREF_IN: assert property (!cke_in && $past(cke_in) && $past(rst_n_in) &&
    cmd == `SCD_CMD_REF |=> cmd_code_out == `SCD_OP_SREF_IN &&
    power_state_out == `SCD_ST_SREF)
    else $error("self refresh entry wrong");
  AST_SREF_OUT: assert property ($rose(cke_in) && power_state_out == `SCD_ST_SREF &&
    (cs_n_in || cmd == `SCD_CMD_NOP) |=> cmd_code_out == `SCD_OP_SREF_OUT &&
    power_state_out == 2'h0)
    else $error("self refresh exit wrong");
  AST_BURST: assert property ($rose(burst_busy_out) |-> burst_busy_out [*2])
    else $error("burst cut short");
  AST_ODT: assert property (power_state_out == `SCD_ST_SREF &&
    $past(power_state_out) == `SCD_ST_SREF |-> !odt_active_out) else $error("odt in self refresh");
endmodule // scd_chk
bind scd_decode scd_chk #(.PAT_VALUE(PAT_VALUE)) u_chk (.*);

/* verification/scd_decode_test.sv */
/* Bench for the command decoder: directed command sequences.
   Assumes the controller model drives all command lines. */
`timescale 1ns/1ps
`include "scd_regs.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module scd_decode_test;
  reg clk_in, rst_n_in, odt;
  wire cke, valid, ap, bc, pmode, prd, ard, busy, refr, odt_act;
  wire [3:0] k, code;
  wire [2:0] ba;
  wire [13:0] ad;
  wire [1:0] pst;
  wire [7:0] pdat;
  integer checked = 0, num_errors = 0, n, i;
  reg [3:0] tk [0:5] = '{4'h3, 4'h2, 4'h2, 4'h1, 4'h6, 4'h6};
  reg ta [0:5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  reg [3:0] te [0:5] = '{4'h7, 4'h5, 4'h6, 4'h2, 4'hA, 4'hB};
  scd_ctrl u_ctrl (.clk_in(clk_in), .cke_out(cke), .cmd_out(k), .ba_out(ba), .addr_out(ad));
  scd_decode i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke), .cs_n_in(k[3]),
    .ras_n_in(k[2]), .cas_n_in(k[1]), .we_n_in(k[0]), .bank_select_in(ba), .addr_in(ad),
    .odt_in(odt), .cmd_valid_out(valid), .cmd_code_out(code), .cmd_bank_out(),
    .cmd_addr_out(), .auto_precharge_select_out(ap), .burst_chop_select_out(bc),
    .pattern_mode_out(pmode), .pattern_read_out(prd), .array_read_out(ard),
    .pattern_data_out(pdat), .burst_busy_out(busy), .refresh_out(refr),
    .power_state_out(pst), .odt_active_out(odt_act));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task stop_test;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmd(input c, input [3:0] kk, input [2:0] b, input [13:0] a, input [3:0] e);
    begin
      u_ctrl.issue(c, kk, b, a);
      #1;
      `CHK("code", e, code)
    end
  endtask
  // Counts busy beats from the decode edge on
  task burst(input integer e);
    begin
      n = 0;
      while (busy === 1'b1 && n < 20)
      begin
        n++;
        @(posedge clk_in);
        #1;
      end
      `CHK("beats", e, n)
      if (n == 20)
        stop_test;
    end
  endtask
  task wake;
    begin
      repeat (2) cmd(1'b1, `SCD_CMD_NOP, 3'h0, 14'h0000, `SCD_OP_NONE);
    end
  endtask
  initial
  begin
    rst_n_in = 1'b0;
    odt = 1'b0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wake;
    cmd(1'b1, `SCD_CMD_RD, 3'h1, 14'h0400, `SCD_OP_RD);
    `CHK("valid", 1'b1, valid)
    `CHK("ap", 1'b1, ap)
    `CHK("array", 1'b1, ard)
    cmd(1'b1, `SCD_CMD_RD, 3'h1, 14'h0000, `SCD_OP_RD);
    burst(2);
    cmd(1'b1, `SCD_CMD_MRS, 3'h0, 14'h0001, `SCD_OP_MRS);
    cmd(1'b1, `SCD_CMD_WR, 3'h2, 14'h0400, `SCD_OP_WR);
    `CHK("chop", 1'b0, bc)
    burst(2);
    cmd(1'b1, `SCD_CMD_MRS, 3'h0, 14'h0002, `SCD_OP_MRS);
    cmd(1'b1, `SCD_CMD_RD, 3'h1, 14'h1000, `SCD_OP_RD);
    burst(2);
    cmd(1'b1, 4'hC, 3'h7, 14'h3FFF, `SCD_OP_NONE);
    for (i = 0; i < 6; i++)
      cmd(1'b1, tk[i], 3'h0, {3'h0, ta[i], 10'h000}, te[i]);
    cmd(1'b1, `SCD_CMD_MRS, 3'h3, 14'h0004, `SCD_OP_MRS);
    `CHK("pmode", 1'b1, pmode)
    cmd(1'b1, `SCD_CMD_RD, 3'h0, 14'h0000, `SCD_OP_RD);
    `CHK("pread", 1'b1, prd)
    `CHK("pdata", 8'h55, pdat)
    burst(2);
    @(posedge clk_in) rst_n_in <= 1'b0;
    #1 `CHK("pmode", 1'b0, pmode)
    @(posedge clk_in) rst_n_in <= 1'b1;
    wake;
    cmd(1'b1, `SCD_CMD_MRS, 3'h3, 14'h0004, `SCD_OP_MRS);
    `CHK("pmode", 1'b1, pmode)
    cmd(1'b1, `SCD_CMD_MRS, 3'h3, 14'h0000, `SCD_OP_MRS);
    `CHK("pmode", 1'b0, pmode)
    cmd(1'b1, `SCD_CMD_RD, 3'h0, 14'h1000, `SCD_OP_RD);
    `CHK("array", 1'b1, ard)
    burst(4);
    @(posedge clk_in) odt <= 1'b1;
    cmd(1'b0, `SCD_CMD_REF, 3'h0, 14'h0000, `SCD_OP_SREF_IN);
    cmd(1'b0, `SCD_CMD_NOP, 3'h0, 14'h0000, `SCD_OP_NONE);
    `CHK("odt", 1'b0, odt_act)
    `CHK("state", 2'h2, pst)
    cmd(1'b1, `SCD_CMD_NOP, 3'h0, 14'h0000, `SCD_OP_SREF_OUT);
    `CHK("state", 2'h0, pst)
    `CHK("odt", 1'b1, odt_act)
    cmd(1'b0, `SCD_CMD_NOP, 3'h0, 14'h0000, `SCD_OP_PDOWN_IN);
    cmd(1'b0, `SCD_CMD_REF, 3'h0, 14'h0000, `SCD_OP_NONE);
    `CHK("refresh", 1'b0, refr)
    cmd(1'b1, `SCD_CMD_NOP, 3'h0, 14'h0000, `SCD_OP_PDOWN_OUT);
    `CHK("state", 2'h0, pst)
    stop_test;
  end
endmodule // scd_decode_test
